// ==== pkg/bus_ctl_pkg.sv ====
`default_nettype none
package bus_ctl_pkg;

	// ==========================================
	// cycle status codes, high bit first
	typedef logic [2:0] status_code_t;

	localparam status_code_t CODE_INT_ACK   = 3'h0;
	localparam status_code_t CODE_IO_READ   = 3'h1;
	localparam status_code_t CODE_IO_WRITE  = 3'h2;
	localparam status_code_t CODE_HALT      = 3'h3;
	localparam status_code_t CODE_FETCH     = 3'h4;
	localparam status_code_t CODE_MEM_READ  = 3'h5;
	localparam status_code_t CODE_MEM_WRITE = 3'h6;
	localparam status_code_t CODE_PASSIVE   = 3'h7;

	// direction mirrors the middle status bit
	localparam int DIR_BIT = 1;

	// ==========================================
	// bus states, two clocks long (two phases) except hold and a T4 or idle cut short by it
	typedef enum logic [2:0] {
		st_idle,
		st_t1,
		st_t2,
		st_t3,
		st_wait,
		st_t4,
		st_hold
	} bus_state_t;

	localparam logic PHASE_FIRST  = 1'h0;
	localparam logic PHASE_SECOND = 1'h1;

	// ==========================================
	// reset values
	localparam logic RST_LOW  = 1'h0;
	localparam logic RST_HIGH = 1'h1;

	// one-hot strobe order in the bus controller
	localparam int STB_MEM_RD  = 0;
	localparam int STB_MEM_WR  = 1;
	localparam int STB_IO_RD   = 2;
	localparam int STB_IO_WR   = 3;
	localparam int STB_INT_ACK = 4;
	localparam int STB_COUNT   = 5;

	function automatic logic is_write(input status_code_t code);
		return code[1] & ~code[0];
	endfunction : is_write

endpackage : bus_ctl_pkg
`default_nettype wire

// ==== pkg/local_bus_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface local_bus_if;
	import bus_ctl_pkg::*;

	logic         mode_select_pin;
	logic         bus_req;
	logic         ready;
	logic         bus_grant_ack;
	logic         xfer_direction_o;
	logic         xfer_direction_oe_n;
	logic         xcvr_output_enable_n_o;
	logic         xcvr_output_enable_n_oe_n;
	status_code_t cycle_status_o;
	logic         cycle_status_oe_n;

	// ==========================================
	// released lines float to logic one
	wire xfer_direction       = xfer_direction_oe_n ? 1'b1 : xfer_direction_o;
	wire xcvr_output_enable_n = xcvr_output_enable_n_oe_n ? 1'b1 : xcvr_output_enable_n_o;
	wire cycle_status_bit0    = cycle_status_oe_n ? 1'b1 : cycle_status_o[0];
	wire cycle_status_bit1    = cycle_status_oe_n ? 1'b1 : cycle_status_o[1];
	wire cycle_status_bit2    = cycle_status_oe_n ? 1'b1 : cycle_status_o[2];

	modport cpu (
		input  mode_select_pin,
		input  bus_req,
		input  ready,
		output bus_grant_ack,
		output xfer_direction_o,
		output xfer_direction_oe_n,
		output xcvr_output_enable_n_o,
		output xcvr_output_enable_n_oe_n,
		output cycle_status_o,
		output cycle_status_oe_n
	);

	modport board (
		output mode_select_pin,
		output bus_req,
		output ready,
		input  bus_grant_ack,
		input  xfer_direction,
		input  xcvr_output_enable_n,
		input  cycle_status_bit0,
		input  cycle_status_bit1,
		input  cycle_status_bit2
	);

endinterface : local_bus_if
`default_nettype wire

// ==== src/bit_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
	parameter int                 WIDTH     = 1,
	parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
	input  wire logic             clock,
	input  wire logic             resetn,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	// ==========================================
	// two-flop chain per bit
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic first;
		always_ff @(posedge clock or negedge resetn) begin
			if (!resetn) begin
				first       <= RESET_VAL[i];
				sync_out[i] <= RESET_VAL[i];
			end else if (clk_en) begin
				first       <= async_in[i];
				sync_out[i] <= first;
			end
		end
	end

endmodule : bit_sync
`default_nettype wire

// ==== src/cpu_bus_end.sv ====
// Summary of operation
// - minimum mode: direction high transmit, low receive
// - direction equals middle status bit, switching at second half of T4
// - direction valid preceding T4 through final T4
// - hold releases direction and enable to one
// - enable asserted for memory, I/O, interrupt acknowledge
// - read/acknowledge: enable mid T2 to mid T4
// - write: enable start T2 to mid T4
// - other master holds request high until acknowledged
// - acknowledge rises mid T4 or idle
// - outputs float together with the acknowledge
// - request low drops acknowledge; drive on next cycle
// - requester meets setup or synchronises its request
// - status coded T4,T1,T2; passive from T3/wait
// - leaving passive starts cycle, returning ends it
// - status floats to ones during grant
// - codes 000 ack, 001 I/O read, 010 I/O write
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_end (
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic              clk_en,
	local_bus_if.cpu               bus,
	input  wire logic              cycle_req,
	input  wire bus_ctl_pkg::status_code_t cycle_kind,
	output var  logic              cycle_take,
	output var  logic              cycle_done,
	output var  logic              bus_released
);
	import bus_ctl_pkg::*;

	bus_state_t   state;
	bus_state_t   next_state;
	logic         phase;
	logic         mode_s;
	logic         hold_s;
	logic         ready_s;
	logic         lead;
	logic         in_cycle;
	logic         floating;
	logic         take;
	logic         ready_end;
	status_code_t next_code;
	status_code_t cur_code;
	status_code_t next_status;
	logic         next_dir;
	logic         next_den;
	logic [2:0]   settle;

	// ==========================================
	// pin synchronisers
	// requester timing
	bit_sync #(
		.WIDTH     (3),
		.RESET_VAL ({RST_HIGH, RST_LOW, RST_LOW})
	) u_sync (
		.clock    (clock),
		.resetn   (resetn),
		.clk_en   (clk_en),
		.async_in ({bus.mode_select_pin, bus.bus_req, bus.ready}),
		.sync_out ({mode_s, hold_s, ready_s})
	);

	// ==========================================
	// bus state sequencing
	assign ready_end = phase & ready_s & (state == st_t3 || state == st_wait);
	assign take      = phase & cycle_req &
		(((state == st_idle) & ~hold_s & settle[2]) | ready_end);

	always_comb begin
		next_state = state;
		unique case (state)
			st_idle: begin
				if (!phase && hold_s) begin
					next_state = st_hold;
				end else if (phase && cycle_req && !hold_s && settle[2]) begin
					next_state = st_t4;
				end
			end
			st_t4: begin
				if (!phase && !lead && hold_s) begin
					next_state = st_hold;
				end else if (phase) begin
					next_state = lead ? st_t1 : st_idle;
				end
			end
			st_t1: begin
				if (phase) begin
					next_state = st_t2;
				end
			end
			st_t2: begin
				if (phase) begin
					next_state = st_t3;
				end
			end
			st_t3, st_wait: begin
				if (phase) begin
					next_state = ready_s ? st_t4 : st_wait;
				end
			end
			st_hold: begin
				if (phase && !hold_s) begin
					next_state = st_idle;
				end
			end
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= st_idle;
			phase <= PHASE_FIRST;
		end else if (clk_en) begin
			state <= next_state;
			phase <= ~phase;
		end
	end

	// ==========================================
	// start-up: pins float until the strap is through the synchroniser
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			settle <= '0;
		end else if (clk_en) begin
			settle <= {settle[1:0], RST_HIGH};
		end
	end

	// ==========================================
	// cycle codes
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			next_code <= CODE_PASSIVE;
			cur_code  <= CODE_PASSIVE;
			lead      <= RST_LOW;
			in_cycle  <= RST_LOW;
		end else if (clk_en) begin
			if (take) begin
				next_code <= cycle_kind;
				lead      <= RST_HIGH;
			end else if (state == st_t4 && phase && lead) begin
				cur_code <= next_code;
				lead     <= RST_LOW;
			end
			// hold from a final T4 skips its second half
			if (state == st_t4 && (phase || next_state == st_hold)) begin
				in_cycle <= lead;
			end
		end
	end

	// ==========================================
	// float control
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			floating <= RST_LOW;
		end else if (clk_en) begin
			if (next_state == st_hold) begin
				floating <= RST_HIGH;
			end else if (take) begin
				floating <= RST_LOW;
			end
		end
	end

	// ==========================================
	// output decode
	always_comb begin
		next_status = CODE_PASSIVE;
		next_dir    = cur_code[DIR_BIT];
		unique case (state)
			st_t4: begin
				if (lead) begin
					next_status = next_code;
				end
				// direction turns only once the enable is off
				if (lead && phase) begin
					next_dir = next_code[DIR_BIT];
				end
			end
			st_t1, st_t2: begin
				next_status = cur_code;
			end
			default: begin
				next_status = CODE_PASSIVE;
			end
		endcase
	end

	assign next_den = (cur_code != CODE_HALT) &
		(((state == st_t2) & (phase | is_write(cur_code))) |
		(state == st_t3) | (state == st_wait) |
		((state == st_t4) & ~phase & in_cycle));

	// ==========================================
	// registered pins
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bus.cycle_status_o            <= CODE_PASSIVE;
			bus.cycle_status_oe_n         <= RST_HIGH;
			bus.xfer_direction_o          <= RST_HIGH;
			bus.xfer_direction_oe_n       <= RST_HIGH;
			bus.xcvr_output_enable_n_o    <= RST_HIGH;
			bus.xcvr_output_enable_n_oe_n <= RST_HIGH;
			bus.bus_grant_ack             <= RST_LOW;
		end else if (clk_en) begin
			bus.cycle_status_o <= next_status;
			bus.cycle_status_oe_n <= mode_s | floating | ~settle[2];
			bus.xfer_direction_o <= next_dir;
			bus.xfer_direction_oe_n       <= ~mode_s | floating | ~settle[2];
			bus.xcvr_output_enable_n_o    <= ~next_den;
			bus.xcvr_output_enable_n_oe_n <= ~mode_s | floating | ~settle[2];
			bus.bus_grant_ack <= (state == st_hold);
		end
	end

	// ==========================================
	// user side
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cycle_take   <= RST_LOW;
			cycle_done   <= RST_LOW;
			bus_released <= RST_LOW;
		end else if (clk_en) begin
			cycle_take   <= take;
			cycle_done   <= ready_end;
			bus_released <= floating;
		end
	end

endmodule : cpu_bus_end
`default_nettype wire

// ==== src/board_bus_end.sv ====
`timescale 1ns/1ns
`default_nettype none
module board_bus_end (
	input  wire logic                        clock,
	input  wire logic                        resetn,
	input  wire logic                        clk_en,
	local_bus_if.board                       bus,
	input  wire logic                        max_mode,
	input  wire logic                        take_bus,
	input  wire logic                        wait_req,
	output var  logic                        bus_owned,
	output var  logic                        cycle_start,
	output var  logic                        cycle_end,
	output var  bus_ctl_pkg::status_code_t   cycle_code,
	output var  logic [bus_ctl_pkg::STB_COUNT-1:0] strobe_n
);
	import bus_ctl_pkg::*;

	logic                 ack_s;
	status_code_t         status_s;
	status_code_t         prev_status;
	logic                 start;
	logic                 stop;
	logic [STB_COUNT-1:0] next_strobe_n;

	// ==========================================
	// pin synchronisers
	bit_sync #(
		.WIDTH     (4),
		.RESET_VAL ({RST_LOW, CODE_PASSIVE})
	) u_sync (
		.clock    (clock),
		.resetn   (resetn),
		.clk_en   (clk_en),
		.async_in ({bus.bus_grant_ack, bus.cycle_status_bit2,
			bus.cycle_status_bit1, bus.cycle_status_bit0}),
		.sync_out ({ack_s, status_s})
	);

	// ==========================================
	// strap, ready and bus request
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bus.mode_select_pin <= RST_HIGH;
			bus.ready           <= RST_HIGH;
			bus.bus_req         <= RST_LOW;
			bus_owned           <= RST_LOW;
		end else if (clk_en) begin
			bus.mode_select_pin <= ~max_mode;
			bus.ready           <= ~wait_req;
			bus.bus_req <= take_bus | (bus.bus_req & ~ack_s);
			bus_owned   <= ack_s & bus.bus_req;
		end
	end

	// ==========================================
	// status decode
	// start and end detection
	assign start = (prev_status == CODE_PASSIVE) & (status_s != CODE_PASSIVE);
	assign stop  = (prev_status != CODE_PASSIVE) & (status_s == CODE_PASSIVE);

	always_comb begin
		next_strobe_n = '1;
		unique case (status_s)
			CODE_FETCH, CODE_MEM_READ: next_strobe_n[STB_MEM_RD] = 1'b0;
			CODE_MEM_WRITE:            next_strobe_n[STB_MEM_WR] = 1'b0;
			CODE_IO_READ:              next_strobe_n[STB_IO_RD] = 1'b0;
			CODE_IO_WRITE:             next_strobe_n[STB_IO_WR] = 1'b0;
			CODE_INT_ACK:              next_strobe_n[STB_INT_ACK] = 1'b0;
			CODE_HALT, CODE_PASSIVE:   next_strobe_n = '1;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prev_status <= CODE_PASSIVE;
			cycle_code  <= CODE_PASSIVE;
			cycle_start <= RST_LOW;
			cycle_end   <= RST_LOW;
			strobe_n    <= '1;
		end else if (clk_en) begin
			prev_status <= status_s;
			cycle_start <= start & max_mode;
			cycle_end   <= stop & max_mode;
			if (start && max_mode) begin
				cycle_code <= status_s;
				strobe_n   <= next_strobe_n;
			end else if (stop || !max_mode) begin
				strobe_n <= '1;
			end
		end
	end

endmodule : board_bus_end
`default_nettype wire

// ==== sim/bus_ctl_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module bus_ctl_chk (
	input wire logic clock,
	input wire logic resetn,
	input wire logic mode_select_pin,
	input wire logic bus_req,
	input wire logic bus_grant_ack,
	input wire logic xfer_direction_oe_n,
	input wire logic xcvr_output_enable_n_oe_n,
	input wire logic cycle_status_oe_n,
	input wire logic xfer_direction,
	input wire logic xcvr_output_enable_n,
	input wire logic cycle_status_bit0,
	input wire logic cycle_status_bit1,
	input wire logic cycle_status_bit2
);
	// ==========================================
	// wire-level checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	wire passive = cycle_status_bit2 & cycle_status_bit1 & cycle_status_bit0;
	wire en_n    = xcvr_output_enable_n;

	float_on_ack_a: assert property (
		bus_grant_ack |-> xfer_direction_oe_n && xcvr_output_enable_n_oe_n && cycle_status_oe_n)
		else $error("outputs driven during grant");
	ones_on_hold_a: assert property (
		bus_grant_ack |-> passive && xfer_direction && en_n)
		else $error("released lines not at one");
	ack_after_req_a: assert property (
		$rose(bus_grant_ack) |-> bus_req && $past(bus_req, 3))
		else $error("acknowledge without request");
	ack_drop_a: assert property (
		$fell(bus_grant_ack) |-> !$past(bus_req, 2))
		else $error("acknowledge dropped early");
	req_held_a: assert property (
		bus_req && !bus_grant_ack |=> bus_req)
		else $error("request dropped before acknowledge");
	dir_min_only_a: assert property (
		!xfer_direction_oe_n |-> mode_select_pin && cycle_status_oe_n)
		else $error("direction driven in maximum mode");
	dir_steady_a: assert property (
		!en_n |-> $stable(xfer_direction) && !xfer_direction_oe_n)
		else $error("direction moved while enabled");
	read_window_a: assert property (
		$fell(en_n) && !xfer_direction |-> !en_n [*4])
		else $error("read enable too short");
	write_window_a: assert property (
		$fell(en_n) && xfer_direction |-> !en_n [*5])
		else $error("write enable too short");
	status_span_a: assert property (
		$fell(passive) |-> !passive [*6] ##1 passive)
		else $error("status span wrong");
endmodule : bus_ctl_chk
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
	import bus_ctl_pkg::*;
	logic                  clock = 1'b0;
	logic                  resetn = 1'b0;
	logic                  cycle_req = 1'b0;
	status_code_t          cycle_kind = CODE_FETCH;
	logic                  max_mode = 1'b0;
	logic                  take_bus = 1'b0;
	logic                  wait_req = 1'b0;
	logic                  cycle_take, cycle_done, bus_released;
	logic                  bus_owned, cycle_start, cycle_end;
	status_code_t          cycle_code;
	logic [STB_COUNT-1:0]  strobe_n;
	int                    miscompares = 0;
	int                    check_count = 0;
	integer                seed = 32'h329f_5d6f;

	always #5 clock = ~clock;

	local_bus_if bus_if ();
	cpu_bus_end i_cpu_bus_end (.clock(clock), .resetn(resetn), .clk_en(1'b1), .bus(bus_if),
		.cycle_req(cycle_req), .cycle_kind(cycle_kind), .cycle_take(cycle_take),
		.cycle_done(cycle_done), .bus_released(bus_released));
	board_bus_end i_board_bus_end (.clock(clock), .resetn(resetn), .clk_en(1'b1), .bus(bus_if),
		.max_mode(max_mode), .take_bus(take_bus), .wait_req(wait_req), .bus_owned(bus_owned),
		.cycle_start(cycle_start), .cycle_end(cycle_end), .cycle_code(cycle_code),
		.strobe_n(strobe_n));
	bus_ctl_chk i_bus_ctl_chk (.clock(clock), .resetn(resetn),
		.mode_select_pin(bus_if.mode_select_pin), .bus_req(bus_if.bus_req),
		.bus_grant_ack(bus_if.bus_grant_ack), .xfer_direction_oe_n(bus_if.xfer_direction_oe_n),
		.xcvr_output_enable_n_oe_n(bus_if.xcvr_output_enable_n_oe_n),
		.cycle_status_oe_n(bus_if.cycle_status_oe_n), .xfer_direction(bus_if.xfer_direction),
		.xcvr_output_enable_n(bus_if.xcvr_output_enable_n),
		.cycle_status_bit0(bus_if.cycle_status_bit0),
		.cycle_status_bit1(bus_if.cycle_status_bit1),
		.cycle_status_bit2(bus_if.cycle_status_bit2));

	// ==========================================
	// expectations
	function automatic logic [STB_COUNT-1:0] exp_strobe(input status_code_t k);
		logic [STB_COUNT-1:0] s;
		s = '1;
		case (k)
			CODE_FETCH, CODE_MEM_READ: s[STB_MEM_RD] = 1'b0;
			CODE_MEM_WRITE: s[STB_MEM_WR] = 1'b0;
			CODE_IO_READ: s[STB_IO_RD] = 1'b0;
			CODE_IO_WRITE: s[STB_IO_WR] = 1'b0;
			CODE_INT_ACK: s[STB_INT_ACK] = 1'b0;
			default: s = '1;
		endcase
		return s;
	endfunction : exp_strobe

	task automatic test_done();
		if (miscompares == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	task automatic do_reset(input logic mode);
		@(posedge clock);
		resetn <= 1'b0;
		max_mode <= mode;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
	endtask : do_reset

	// ==========================================
	// one bus cycle, optionally behind a grant
	task automatic run_cycle(input status_code_t k, input logic hold);
		int n;
		int dones;
		int ends;
		logic en_seen;
		logic dir;
		status_code_t code;
		logic [STB_COUNT-1:0] stb;
		dones = 0;
		ends = 0;
		en_seen = 1'b0;
		dir = 1'bx;
		code = CODE_PASSIVE;
		stb = '1;
		@(posedge clock);
		cycle_req <= 1'b1;
		cycle_kind <= k;
		wait_req <= 1'($random(seed));
		for (n = 0; n < 80 && cycle_take !== 1'b1; n++) begin
			@(negedge clock);
			if (hold && n == 10) begin
				`CHK(bus_released, 1'b1)
				`CHK({bus_if.xfer_direction, bus_if.xcvr_output_enable_n, bus_if.cycle_status_bit2,
					bus_if.cycle_status_bit1, bus_if.cycle_status_bit0}, 5'h1f)
				@(posedge clock);
				take_bus <= 1'b0;
			end
		end
		`CHK(cycle_take, 1'b1)
		`CHK(n > 11 || !hold, 1'b1)
		`CHK(bus_if.bus_grant_ack, 1'b0)
		for (n = 0; n < 40; n++) begin
			@(posedge clock);
			cycle_req <= 1'b0;
			if (n == 6)
				wait_req <= 1'b0;
			@(negedge clock);
			if (bus_if.xcvr_output_enable_n === 1'b0)
				en_seen = 1'b1;
			if (cycle_done === 1'b1) begin
				dones++;
				dir = bus_if.xfer_direction;
			end
			if (cycle_start === 1'b1)
				code = cycle_code;
			if (cycle_end === 1'b1)
				ends++;
			stb = stb & strobe_n;
		end
		`CHK(dones, 1)
		if (max_mode) begin
			`CHK(code, k)
			`CHK(stb, exp_strobe(k))
			`CHK(ends, 1)
			`CHK(en_seen, 1'b0)
		end else begin
			`CHK(dir, k[DIR_BIT])
			`CHK(en_seen, k != CODE_HALT)
		end
	endtask : run_cycle

	// ==========================================
	// main sequence
	initial begin
		for (int m = 0; m < 2; m++) begin
			do_reset(m[0]);
			for (int k = 0; k < 7; k++)
				run_cycle(3'(k), 1'b0);
			repeat (8) begin
				logic h;
				h = 1'($random(seed));
				if (h) begin
					@(posedge clock);
					take_bus <= 1'b1;
					for (int w = 0; w < 30 && bus_owned !== 1'b1; w++)
						@(negedge clock);
					`CHK(bus_owned, 1'b1)
				end
				run_cycle(3'({$random(seed)} % 7), h);
			end
		end
		test_done();
	end

	initial begin
		#200000;
		miscompares++;
		test_done();
	end
endmodule : tb_top
`default_nettype wire
